// *** rtl/ipv_pkg.sv ***
// constants for the priority, vector base and fast interrupt block
// assumes a 16-bit register view carried on a 32-bit apb data bus
package ipv_pkg;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 6;
  localparam int NUM_REQ = 8;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PRIO_NINE = 6'h09;
  localparam logic [IDX_W-1:0] IDX_VEC_BASE = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_F0_SELECT = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_F0_ADDR_LOW = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_F0_ADDR_HIGH = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_F1_SELECT = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_F1_ADDR_LOW = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_F1_ADDR_HIGH = 6'h10;

  // field layout
  localparam int LEVEL_W = 2;
  localparam int FIELD_POS_TOP = 14;
  localparam int BASE_W = 13;
  localparam int VECNUM_W = 7;
  localparam int FAST_HI_W = 5;
  localparam int FAST_LO_W = 16;
  localparam int VAB_W = 21;
  localparam int RANK_W = 4;

  // level field encodings
  localparam logic [LEVEL_W-1:0] LEVEL_OFF = 2'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_0 = 2'h1;
  localparam logic [LEVEL_W-1:0] LEVEL_1 = 2'h2;
  localparam logic [LEVEL_W-1:0] LEVEL_2 = 2'h3;

  // reset values
  localparam logic [REG_W-1:0] PRIO_RESET = 16'h0000;
  localparam logic [BASE_W-1:0] BASE_RESET = 13'h0000;
  localparam logic [VECNUM_W-1:0] SELECT_RESET = 7'h00;
  localparam logic [FAST_LO_W-1:0] ADDR_LOW_RESET = 16'h0000;
  localparam logic [FAST_HI_W-1:0] ADDR_HIGH_RESET = 5'h00;
  localparam logic [VAB_W-1:0] VAB_RESET = 21'h000000;
endpackage

// *** rtl/ipv_arbiter.sv ***
// combinational winner pick among the peripheral requests
// assumes requests and level fields come from logic on the same clock
`timescale 1ns/1ns
module ipv_arbiter #(
  parameter int N = ipv_pkg::NUM_REQ,
  parameter int IW = $clog2(N)
)
(
  input wire logic [N-1:0] reqPending,
  input wire logic [2*N-1:0] reqLevel,
  input wire logic [N-1:0] fast0Hit,
  input wire logic [N-1:0] fast1Hit,
  output logic winValid,
  output logic [IW-1:0] winIndex,
  output logic [ipv_pkg::LEVEL_W-1:0] winLevel,
  output logic winFast0,
  output logic winFast1
);
  logic [ipv_pkg::RANK_W-1:0] rank [N];

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_rank
      logic [ipv_pkg::LEVEL_W-1:0] lvl;
      logic active;
      assign lvl = reqLevel[2*g +: ipv_pkg::LEVEL_W];
      assign active = reqPending[g] && (lvl != ipv_pkg::LEVEL_OFF); // R1
      // fast bits sit above the level so a fast request beats plain level 2
      assign rank[g] = active ? {fast0Hit[g], fast1Hit[g], lvl} : '0; // R11 R12
    end
  endgenerate

  always_comb
  begin
    logic [ipv_pkg::RANK_W-1:0] best;
    best = '0;
    winIndex = '0;
    for (int i = 0; i < N; i++)
    begin
      // strict compare keeps the lowest vector on a tie
      if (rank[i] > best) // R18
      begin
        best = rank[i];
        winIndex = IW'(i);
      end
    end
    winValid = (best != '0);
    winFast0 = best[3]; // R12
    winFast1 = best[3:2] == 2'h1;
    winLevel = best[1:0];
  end
endmodule // ipv_arbiter

// *** rtl/ipv_irq_vector.sv ***
// priority fields, vector base, fast interrupt selects and vector output
// assumes apb master on the same clock and request levels held until serviced
`timescale 1ns/1ns
// Function
// (R1) field codes: off, level 0, 1, 2
// (R2) sources reset disabled, levels 0 to 2
// (R3) pwm fault and reload fields in 15:8
// (R4) adc zero-cross and done fields in 7:0
// (R5) base forms upper 13 vector bits
// (R6) low eight bits from winning request
// (R7) base bits 15:13 read zero
// (R8) fast 0 select holds vector number
// (R9) fast interrupt drives handler address directly
// (R10) software sets fast requests to level 2
// (R11) fast request beats other level 2
// (R12) fast 0 served before fast 1
// (R13) fast 0 address is 16 plus 5 bits
// (R14) fast 0 high bits 15:5 read zero
// (R15) fast 0 select bits 15:7 read zero
// (R16) fast 1 select at index 0xE
// (R17) fast 1 address is 21 bits too
// (R18) highest level wins, ties by vector
module ipv_irq_vector #(
  parameter int ADDR_W = 8,
  parameter logic [ipv_pkg::VECNUM_W-1:0] FIRST_VECTOR = 7'h10
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [ipv_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [ipv_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pwmAFault,
  input wire logic pwmBFault,
  input wire logic pwmAReload,
  input wire logic pwmBReload,
  input wire logic adcAZeroCross,
  input wire logic adcBZeroCross,
  input wire logic adcADone,
  input wire logic adcBDone,
  output logic irqRequest,
  output logic [ipv_pkg::LEVEL_W-1:0] irqLevel,
  output logic fastTaken,
  output logic [ipv_pkg::VAB_W-1:0] vectorAddressBus
);
  localparam int N = ipv_pkg::NUM_REQ;
  localparam int IW = $clog2(N);

  // checks sample on the system clock and stay quiet while reset is high
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  logic [ipv_pkg::REG_W-1:0] peripheralPriorityNine;
  logic [ipv_pkg::BASE_W-1:0] vectorTableBase;
  logic [ipv_pkg::VECNUM_W-1:0] fastIrq0Select;
  logic [ipv_pkg::FAST_LO_W-1:0] fastIrq0AddrLow;
  logic [ipv_pkg::FAST_HI_W-1:0] fastIrq0AddrHigh;
  logic [ipv_pkg::VECNUM_W-1:0] fastIrq1Select;
  logic [ipv_pkg::FAST_LO_W-1:0] fastIrq1AddrLow;
  logic [ipv_pkg::FAST_HI_W-1:0] fastIrq1AddrHigh;

  localparam int IDX_W_L = ipv_pkg::IDX_W;
  logic [IDX_W_L-1:0] regIndex;
  logic setupPhase;
  logic writeAccess;
  logic indexMapped;
  logic [ipv_pkg::REG_W-1:0] readValue;

  logic [N-1:0] reqPending;
  logic [2*N-1:0] reqLevel;
  logic [N-1:0] fast0Hit;
  logic [N-1:0] fast1Hit;
  logic [N-1:0] reqEnabled;
  logic [ipv_pkg::VECNUM_W-1:0] reqVector [N];
  logic winValid;
  logic [IW-1:0] winIndex;
  logic [ipv_pkg::LEVEL_W-1:0] winLevel;
  logic winFast0;
  logic winFast1;
  logic [ipv_pkg::VAB_W-1:0] next_vectorAddressBus;
  logic [ipv_pkg::VECNUM_W-1:0] winVector;

  // merge a 16-bit register value with the enabled low byte lanes
  function automatic logic [ipv_pkg::REG_W-1:0] merge16(
    input logic [ipv_pkg::REG_W-1:0] old,
    input logic [ipv_pkg::DATA_W-1:0] wdata,
    input logic [3:0] strb
  );
    logic [ipv_pkg::REG_W-1:0] res;
    res = old;
    if (strb[0])
      res[7:0] = wdata[7:0];
    if (strb[1])
      res[15:8] = wdata[15:8];
    return res;
  endfunction

  // apb decode
  assign regIndex = paddr[ipv_pkg::ADDR_LSB +: IDX_W_L];
  assign setupPhase = psel && !penable;
  assign writeAccess = psel && penable && pready && pwrite;
  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;

  always_comb
  begin
    indexMapped = 1'b1;
    readValue = '0;
    case (regIndex)
      ipv_pkg::IDX_PRIO_NINE: readValue = peripheralPriorityNine;
      ipv_pkg::IDX_VEC_BASE: readValue = {3'h0, vectorTableBase}; // R7
      ipv_pkg::IDX_F0_SELECT: readValue = {9'h000, fastIrq0Select}; // R15
      ipv_pkg::IDX_F0_ADDR_LOW: readValue = fastIrq0AddrLow;
      ipv_pkg::IDX_F0_ADDR_HIGH: readValue = {11'h000, fastIrq0AddrHigh}; // R14
      ipv_pkg::IDX_F1_SELECT: readValue = {9'h000, fastIrq1Select}; // R16
      ipv_pkg::IDX_F1_ADDR_LOW: readValue = fastIrq1AddrLow;
      ipv_pkg::IDX_F1_ADDR_HIGH: readValue = {11'h000, fastIrq1AddrHigh};
      default: indexMapped = 1'b0;
    endcase
  end

  // read data and error are captured in setup so they come from flops
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (setupPhase)
    begin
      prdata <= pwrite ? '0 : {16'h0000, readValue};
      pslverr <= !indexMapped;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      peripheralPriorityNine <= ipv_pkg::PRIO_RESET; // R2
    else if (writeAccess && regIndex == ipv_pkg::IDX_PRIO_NINE)
      peripheralPriorityNine <= merge16(peripheralPriorityNine, pwdata, pstrb); // R3 R4
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      vectorTableBase <= ipv_pkg::BASE_RESET;
    else if (writeAccess && regIndex == ipv_pkg::IDX_VEC_BASE)
      vectorTableBase <= 13'(merge16({3'h0, vectorTableBase}, pwdata, pstrb)); // R7
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      fastIrq0Select <= ipv_pkg::SELECT_RESET;
      fastIrq0AddrLow <= ipv_pkg::ADDR_LOW_RESET;
      fastIrq0AddrHigh <= ipv_pkg::ADDR_HIGH_RESET;
    end
    else if (writeAccess)
    begin
      // reserved bits have no flops, so writes to them are simply lost
      if (regIndex == ipv_pkg::IDX_F0_SELECT)
        fastIrq0Select <= 7'(merge16({9'h000, fastIrq0Select}, pwdata, pstrb)); // R8 R15
      if (regIndex == ipv_pkg::IDX_F0_ADDR_LOW)
        fastIrq0AddrLow <= merge16(fastIrq0AddrLow, pwdata, pstrb); // R13
      if (regIndex == ipv_pkg::IDX_F0_ADDR_HIGH)
        fastIrq0AddrHigh <= 5'(merge16({11'h000, fastIrq0AddrHigh}, pwdata, pstrb)); // R14
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      fastIrq1Select <= ipv_pkg::SELECT_RESET;
      fastIrq1AddrLow <= ipv_pkg::ADDR_LOW_RESET;
      fastIrq1AddrHigh <= ipv_pkg::ADDR_HIGH_RESET;
    end
    else if (writeAccess)
    begin
      if (regIndex == ipv_pkg::IDX_F1_SELECT)
        fastIrq1Select <= 7'(merge16({9'h000, fastIrq1Select}, pwdata, pstrb)); // R16
      if (regIndex == ipv_pkg::IDX_F1_ADDR_LOW)
        fastIrq1AddrLow <= merge16(fastIrq1AddrLow, pwdata, pstrb); // R17
      if (regIndex == ipv_pkg::IDX_F1_ADDR_HIGH)
        fastIrq1AddrHigh <= 5'(merge16({11'h000, fastIrq1AddrHigh}, pwdata, pstrb)); // R17
    end
  end

  // request order matches field order, top field first
  assign reqPending = {adcBDone, adcADone, adcBZeroCross, adcAZeroCross,
                       pwmBReload, pwmAReload, pwmBFault, pwmAFault};

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_req
      // request g reads the field 2*g bits below the top one
      assign reqLevel[2*g +: ipv_pkg::LEVEL_W] =
        peripheralPriorityNine[ipv_pkg::FIELD_POS_TOP - 2*g +: ipv_pkg::LEVEL_W]; // R3 R4
      assign reqVector[g] = FIRST_VECTOR + ipv_pkg::VECNUM_W'(g);
      assign fast0Hit[g] = (reqVector[g] == fastIrq0Select); // R8
      assign fast1Hit[g] = (reqVector[g] == fastIrq1Select); // R16
      assign reqEnabled[g] = (reqLevel[2*g +: ipv_pkg::LEVEL_W] != ipv_pkg::LEVEL_OFF); // R1
      // outside a fast win no enabled pending request outranks the winner
      a_level_max: assert property (reqPending[g] && reqEnabled[g] && !winFast0 // R18
        && !winFast1 |-> reqLevel[2*g +: ipv_pkg::LEVEL_W] <= winLevel)
        else $error("lower level request won");
    end
  endgenerate

  ipv_arbiter #(
    .N(N),
    .IW(IW)
  ) u_arbiter (
    .reqPending(reqPending),
    .reqLevel(reqLevel),
    .fast0Hit(fast0Hit),
    .fast1Hit(fast1Hit),
    .winValid(winValid),
    .winIndex(winIndex),
    .winLevel(winLevel),
    .winFast0(winFast0),
    .winFast1(winFast1)
  );

  assign winVector = reqVector[winIndex];

  always_comb
  begin
    if (winFast0)
      next_vectorAddressBus = {fastIrq0AddrHigh, fastIrq0AddrLow}; // R9 R13
    else if (winFast1)
      next_vectorAddressBus = {fastIrq1AddrHigh, fastIrq1AddrLow}; // R9 R17
    else if (winValid)
      // two table words per vector, so the number sits one bit up
      next_vectorAddressBus = {vectorTableBase, winVector, 1'b0}; // R5 R6
    else
      next_vectorAddressBus = {vectorTableBase, 8'h00};
  end

  // one registered stage toward the core; follows the requests every cycle
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      irqRequest <= 1'b0;
      irqLevel <= ipv_pkg::LEVEL_OFF;
      fastTaken <= 1'b0;
      vectorAddressBus <= ipv_pkg::VAB_RESET;
    end
    else
    begin
      irqRequest <= winValid;
      irqLevel <= winLevel;
      fastTaken <= winFast0 || winFast1;
      vectorAddressBus <= next_vectorAddressBus;
    end
  end

  a_disabled_silent: assert property (peripheralPriorityNine == 16'h0000 |=> !irqRequest) // R1
    else $error("request raised with all fields disabled");
  a_level_code: assert property (irqRequest |-> irqLevel != ipv_pkg::LEVEL_OFF) // R1
    else $error("request raised with level code zero");
  a_reset_cleared: assert property ($past(reset) |-> peripheralPriorityNine == 16'h0000) // R2
    else $error("priority fields not cleared by reset");
  a_regs_reset: assert property ($past(reset) |-> vectorTableBase == ipv_pkg::BASE_RESET // R2
    && fastIrq0Select == ipv_pkg::SELECT_RESET && fastIrq1Select == ipv_pkg::SELECT_RESET
    && fastIrq0AddrLow == ipv_pkg::ADDR_LOW_RESET
    && fastIrq0AddrHigh == ipv_pkg::ADDR_HIGH_RESET)
    else $error("register not cleared by reset");

  // field placement and the table vector
  a_pwm_field: assert property ((reqPending == 8'h01) // R3
    && (peripheralPriorityNine[15:14] != 2'h0)
    && (fastIrq0Select != FIRST_VECTOR) && (fastIrq1Select != FIRST_VECTOR)
    |=> irqRequest && vectorAddressBus[7:0] == {FIRST_VECTOR, 1'b0}
    && irqLevel == $past(peripheralPriorityNine[15:14]))
    else $error("pwm fault field misplaced");
  a_adc_field: assert property ((reqPending == 8'h80) // R4
    && (peripheralPriorityNine[1:0] == 2'h0) |=> !irqRequest)
    else $error("adc done field misplaced");
  a_prio_write: assert property (writeAccess && regIndex == ipv_pkg::IDX_PRIO_NINE // R3 R4
    && pstrb[1:0] == 2'h3 |=> peripheralPriorityNine == $past(pwdata[15:0]))
    else $error("priority write not stored");
  a_base_upper: assert property (irqRequest && !fastTaken // R5
    |-> vectorAddressBus[20:8] == $past(vectorTableBase))
    else $error("vector base not on upper bits");
  a_idle_base: assert property (!winValid // R5
    |=> vectorAddressBus == {$past(vectorTableBase), 8'h00})
    else $error("idle vector not base with zero low byte");
  a_low_vector: assert property (winValid && !winFast0 && !winFast1 // R6
    |=> vectorAddressBus[7:1] == $past(winVector) && !vectorAddressBus[0])
    else $error("low vector bits wrong");

  // register writes and reserved bits
  a_base_reserved: assert property (psel && penable && !pwrite // R7
    && regIndex == ipv_pkg::IDX_VEC_BASE |-> prdata[31:13] == 19'h00000)
    else $error("base reserved bits not zero");
  a_base_write: assert property (writeAccess && regIndex == ipv_pkg::IDX_VEC_BASE // R7
    && pstrb[1:0] == 2'h3 |=> vectorTableBase == $past(pwdata[12:0]))
    else $error("base write not stored");
  a_sel0_write: assert property (writeAccess && regIndex == ipv_pkg::IDX_F0_SELECT // R8
    && pstrb[0] |=> fastIrq0Select == $past(pwdata[6:0]))
    else $error("fast 0 select write not stored");
  a_low0_write: assert property (writeAccess && regIndex == ipv_pkg::IDX_F0_ADDR_LOW // R13
    && pstrb[1:0] == 2'h3 |=> fastIrq0AddrLow == $past(pwdata[15:0]))
    else $error("fast 0 low address write not stored");
  a_high0_write: assert property (writeAccess && regIndex == ipv_pkg::IDX_F0_ADDR_HIGH // R14
    && pstrb[0] |=> fastIrq0AddrHigh == $past(pwdata[4:0]))
    else $error("fast 0 high address write not stored");
  a_high_reserved: assert property (psel && penable && !pwrite // R14
    && regIndex == ipv_pkg::IDX_F0_ADDR_HIGH |-> prdata[31:5] == 27'h0000000)
    else $error("fast 0 high reserved bits not zero");
  a_select_reserved: assert property (psel && penable && !pwrite // R15 R16
    && (regIndex == ipv_pkg::IDX_F0_SELECT || regIndex == ipv_pkg::IDX_F1_SELECT)
    |-> prdata[31:7] == 25'h0000000)
    else $error("select reserved bits not zero");
  a_sel1_write: assert property (writeAccess && regIndex == ipv_pkg::IDX_F1_SELECT // R16
    && pstrb[0] |=> fastIrq1Select == $past(pwdata[6:0]))
    else $error("fast 1 select write not stored");
  a_low1_write: assert property (writeAccess && regIndex == ipv_pkg::IDX_F1_ADDR_LOW // R17
    && pstrb[1:0] == 2'h3 |=> fastIrq1AddrLow == $past(pwdata[15:0]))
    else $error("fast 1 low address write not stored");
  a_high1_write: assert property (writeAccess && regIndex == ipv_pkg::IDX_F1_ADDR_HIGH // R17
    && pstrb[0] |=> fastIrq1AddrHigh == $past(pwdata[4:0]))
    else $error("fast 1 high address write not stored");

  // fast interrupt selection and direct handler addresses
  a_fast0_direct: assert property (winFast0 // R9 R13
    |=> fastTaken && vectorAddressBus == $past({fastIrq0AddrHigh, fastIrq0AddrLow}))
    else $error("fast 0 address not driven");
  a_fast1_direct: assert property (winFast1 // R9 R17
    |=> fastTaken && vectorAddressBus == $past({fastIrq1AddrHigh, fastIrq1AddrLow}))
    else $error("fast 1 address not driven");
  a_fast_flagged: assert property (fastTaken |-> irqRequest) // R9
    else $error("fast flag without request");
  a_fast_outrank: assert property (winValid && |(fast1Hit & reqPending) // R11
    && !(|(fast0Hit & reqPending)) && winLevel == ipv_pkg::LEVEL_2 |-> winFast1)
    else $error("fast 1 lost to plain level 2");
  a_fast0_first: assert property (winFast0 |-> !winFast1 ##1 fastTaken [*1]) // R12
    else $error("fast 1 taken over fast 0");
  a_fast0_over1: assert property (|(fast0Hit & reqPending & reqEnabled) // R12
    && |(fast1Hit & reqPending & reqEnabled) |-> winFast0 && !winFast1)
    else $error("fast 1 chosen while fast 0 pending");
endmodule // ipv_irq_vector

// *** dv/ipv_core_model.sv ***
// core-side model: takes the vector address whenever a request is raised
// assumes the block's outputs are registered on the same clock
`timescale 1ns/1ns
module ipv_core_model
(
  input wire logic clock,
  input wire logic reset,
  input wire logic irqRequest,
  input wire logic fastTaken,
  input wire logic [ipv_pkg::VAB_W-1:0] vectorAddressBus,
  output logic [ipv_pkg::VAB_W-1:0] lastVector,
  output logic lastFast
);
  // no acknowledge: the core only samples what it is offered
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      lastVector <= '0;
      lastFast <= 1'b0;
    end
    else if (irqRequest)
    begin
      lastVector <= vectorAddressBus;
      lastFast <= fastTaken;
    end
  end
endmodule // ipv_core_model

// *** dv/tb.sv ***
// self-checking bench: apb register tests, level mapping, priority and fast vectors
// assumes zero-wait apb slave and one-cycle registered request path
`timescale 1ns/1ns
module tb;
  localparam logic [6:0] FV = 7'h10;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] reqs = 8'h00;
  logic [31:0] prdata;
  logic pready, pslverr, irqRequest, fastTaken, lastFast;
  logic [1:0] irqLevel;
  logic [20:0] vectorAddressBus, lastVector;
  int fails = 0;
  int checks = 0;
  always #5 clock = ~clock;
  ipv_irq_vector #(.ADDR_W(8), .FIRST_VECTOR(FV)) uut (.clock(clock), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwmAFault(reqs[0]), .pwmBFault(reqs[1]), .pwmAReload(reqs[2]), .pwmBReload(reqs[3]),
    .adcAZeroCross(reqs[4]), .adcBZeroCross(reqs[5]), .adcADone(reqs[6]), .adcBDone(reqs[7]),
    .irqRequest(irqRequest), .irqLevel(irqLevel), .fastTaken(fastTaken),
    .vectorAddressBus(vectorAddressBus));
  ipv_core_model core (.clock(clock), .reset(reset), .irqRequest(irqRequest),
    .fastTaken(fastTaken), .vectorAddressBus(vectorAddressBus), .lastVector(lastVector),
    .lastFast(lastFast));
  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL t=%0t data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_out(input logic r, input logic [1:0] l, input logic f, input logic [20:0] v);
    checks++;
    if ({irqRequest, irqLevel, fastTaken, vectorAddressBus} !== {r, l, f, v})
    begin
      fails++;
      $display("FAIL t=%0t outputs %b %h %b %h", $time, irqRequest, irqLevel, fastTaken,
        vectorAddressBus);
    end
  endtask
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fails++;
      $display("FAIL t=%0t apb answer timeout", $time);
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, {16'h0000, d}, r, e);
  endtask
  task automatic rd_chk(input logic [5:0] idx, input logic [15:0] exp, input logic expErr);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h00000000, r, e);
    chk_rd(r, {16'h0000, exp});
    chk_rd({31'h0, e}, {31'h0, expErr});
  endtask
  // lets the registered request path catch up with new inputs
  task automatic settle(input logic [7:0] r);
    @(posedge clock);
    reqs <= r;
    repeat (2) @(posedge clock);
    #1;
  endtask
  function automatic logic [15:0] mask(input int k);
    case (k)
      10: mask = 16'h1FFF;
      11, 14: mask = 16'h007F;
      13, 16: mask = 16'h001F;
      default: mask = 16'hFFFF;
    endcase
  endfunction
  initial
  begin
    #50000;
    fails++;
    $display("FAIL t=%0t watchdog expired", $time);
    tally_and_finish();
  end
  initial
  begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    #1 chk_out(1'b0, 2'h0, 1'b0, 21'h000000);
    for (int k = 9; k <= 16; k++)
      rd_chk(k[5:0], 16'h0000, 1'b0);
    wr(6'h11, 16'hFFFF);
    rd_chk(6'h11, 16'h0000, 1'b1);
    for (int k = 9; k <= 16; k++)
    begin
      wr(k[5:0], 16'hFFFF);
      rd_chk(k[5:0], mask(k), 1'b0);
      wr(k[5:0], 16'h0000);
    end
    pstrb <= 4'h1;
    wr(ipv_pkg::IDX_PRIO_NINE, 16'h1234);
    pstrb <= 4'hF;
    rd_chk(ipv_pkg::IDX_PRIO_NINE, 16'h0034, 1'b0);
    wr(ipv_pkg::IDX_VEC_BASE, 16'h0155);
    for (int i = 0; i < 8; i++)
      for (int c = 0; c < 4; c++)
      begin
        wr(ipv_pkg::IDX_PRIO_NINE, 16'(c << (14 - 2 * i)));
        settle(8'(1 << i));
        chk_out(c != 0, 2'(c), 1'b0, (c != 0) ? {13'h0155, 7'(FV + i), 1'b0}
          : {13'h0155, 8'h00});
      end
    // fields: req1 level 1, req2 level 2, req5 level 2
    wr(ipv_pkg::IDX_PRIO_NINE, 16'h2C30);
    settle(8'hFF);
    chk_out(1'b1, 2'h3, 1'b0, {13'h0155, 7'(FV + 2), 1'b0});
    settle(8'h22);
    chk_out(1'b1, 2'h3, 1'b0, {13'h0155, 7'(FV + 5), 1'b0});
    wr(ipv_pkg::IDX_PRIO_NINE, 16'hFFFF);
    wr(ipv_pkg::IDX_F0_ADDR_LOW, 16'hBEEF);
    wr(ipv_pkg::IDX_F0_ADDR_HIGH, 16'h0015);
    wr(ipv_pkg::IDX_F1_ADDR_LOW, 16'h1234);
    wr(ipv_pkg::IDX_F1_ADDR_HIGH, 16'h000A);
    wr(ipv_pkg::IDX_F1_SELECT, {9'h000, 7'(FV + 6)});
    settle(8'hFF);
    chk_out(1'b1, 2'h3, 1'b1, {5'h0A, 16'h1234});
    wr(ipv_pkg::IDX_F0_SELECT, {9'h000, 7'(FV + 7)});
    settle(8'hFF);
    chk_out(1'b1, 2'h3, 1'b1, {5'h15, 16'hBEEF});
    settle(8'h7F);
    chk_out(1'b1, 2'h3, 1'b1, {5'h0A, 16'h1234});
    chk_rd({10'h000, lastFast, lastVector}, {10'h000, 1'b1, 5'h0A, 16'h1234});
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    #1 chk_out(1'b0, 2'h0, 1'b0, 21'h000000);
    @(posedge clock);
    reset <= 1'b0;
    rd_chk(ipv_pkg::IDX_PRIO_NINE, 16'h0000, 1'b0);
    rd_chk(ipv_pkg::IDX_F0_SELECT, 16'h0000, 1'b0);
    tally_and_finish();
  end
endmodule // tb
